// ===== common/mdu_map.vh
// constants for the multiply/divide unit
// Contract
// - mdu pipeline runs beside integer pipeline and keeps advancing when it stalls
// - multiplier is booth-recoded array: 32-bit rs by 16-bit rt slice per pass
// - results land in hi/lo pair, mul results in a gpr; a state machine steers the divide
// - size is set from rt only: one pass up to 32x16, two for 32x32
// - short multiply accepted every cycle, 32x32 at most every second cycle
// - back-to-back 32x32 multiplies stall until first one's second pass is done
// - divider yields one quotient bit per clock
// - early-in skips 23, 15 or 7 iterations for 8, 16 or 24-bit dividends
// - any mdu instruction other than a divide stalls during an active divide until it ends; a divide issues on its last cycle
// - hi/lo multiplies: latency 1 rate 1 at 16 bits, latency 2 rate 2 at 32
// - gpr multiply: latency 2 rate 1 at 16 bits, latency 3 rate 2 at 32
// - divide latency 12/19/26/33 by dividend width, repeat one clock less
// - latency counts clocks until result usable, repeat until same op reissues
`ifndef MDU_MAP_VH
`define MDU_MAP_VH

// opcode encodings on OP_CODE_I
`define MDU_OP_MULT 4'h0
`define MDU_OP_MULTU 4'h1
`define MDU_OP_MADD 4'h2
`define MDU_OP_MADDU 4'h3
`define MDU_OP_MSUB 4'h4
`define MDU_OP_MSUBU 4'h5
`define MDU_OP_MUL 4'h6
`define MDU_OP_DIV 4'h7
`define MDU_OP_DIVU 4'h8

// divide latencies in pipeline clocks, by dividend width
`define MDU_DIV_LAT_8 6'h0C
`define MDU_DIV_LAT_16 6'h13
`define MDU_DIV_LAT_24 6'h1A
`define MDU_DIV_LAT_32 6'h21

// iterations skipped by early-in detection
`define MDU_SKIP_8 6'h17
`define MDU_SKIP_16 6'h0F
`define MDU_SKIP_24 6'h07
`define MDU_DIV_BITS 6'h20

`endif

// ===== verilog/mdu_div.v
// iterative one-bit-per-clock divider with early-in detection
`default_nettype none
`include "mdu_map.vh"

module mdu_div (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire start_i,
  input wire sign_i,
  input wire [31:0] rs_i,
  input wire [31:0] rt_i,
  output wire busy_o,
  output wire last_o,
  output wire [31:0] quo_o,
  output wire [31:0] rem_o
);
  localparam ST_IDLE = 2'b00;
  localparam ST_RUN = 2'b01;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [31:0] rem_ff;
  reg [31:0] quo_ff;
  reg [31:0] dvs_ff;
  reg [5:0] iter_ff;
  reg [5:0] cnt_ff;
  reg neg_q_ff;
  reg neg_r_ff;

  // one restoring step: shift in next dividend bit, subtract if it fits
  function [63:0] div_step;
    input [31:0] rem;
    input [31:0] quo;
    input [31:0] dvs;
    reg [32:0] r2;
    reg [32:0] diff;
    begin
      r2 = {rem, quo[31]};
      diff = r2 - {1'b0, dvs};
      if (!diff[32]) begin
        div_step = {diff[31:0], quo[30:0], 1'b1};
      end else begin
        div_step = {r2[31:0], quo[30:0], 1'b0};
      end
    end
  endfunction

  // true when the value has nothing set at or above bit sh
  function fits;
    input [31:0] t;
    input [5:0] sh;
    begin
      fits = ((t >> sh) == 32'h0000_0000);
    end
  endfunction

  // operand magnitudes and width class of the dividend
  wire rs_neg = sign_i & rs_i[31];
  wire rt_neg = sign_i & rt_i[31];
  wire [31:0] rs_mag = rs_neg ? (32'h0000_0000 - rs_i) : rs_i;
  wire [31:0] rt_mag = rt_neg ? (32'h0000_0000 - rt_i) : rt_i;
  // ones complement folds the sign so one shift tests the sign extension
  wire [31:0] rs_fold = rs_i ^ {32{rs_neg}};
  wire [5:0] sg = {5'h00, sign_i};
  reg [5:0] skip;
  reg [5:0] lat;
  always @* begin
    if (fits(rs_fold, 6'h08 - sg)) begin
      skip = `MDU_SKIP_8;
      lat = `MDU_DIV_LAT_8;
    end else if (fits(rs_fold, 6'h10 - sg)) begin
      skip = `MDU_SKIP_16;
      lat = `MDU_DIV_LAT_16;
    end else if (fits(rs_fold, 6'h18 - sg)) begin
      skip = `MDU_SKIP_24;
      lat = `MDU_DIV_LAT_24;
    end else begin
      skip = 6'h00;
      lat = `MDU_DIV_LAT_32;
    end
  end

  // first step is taken at the start edge so a full 32-bit divide still fits
  wire [63:0] first = div_step(32'h0000_0000, rs_mag << skip, rt_mag);
  wire [63:0] step = div_step(rem_ff, quo_ff, dvs_ff);

  // divide state machine
  always @* begin
    case (state_ff)
      ST_IDLE: begin
        nxt_state = start_i ? ST_RUN : ST_IDLE;
      end
      ST_RUN: begin
        nxt_state = (cnt_ff == 6'h01) ? ST_IDLE : ST_RUN;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // datapath; a start is only presented when idle or on the last cycle
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_IDLE;
      rem_ff <= 32'h0000_0000;
      quo_ff <= 32'h0000_0000;
      dvs_ff <= 32'h0000_0000;
      iter_ff <= 6'h00;
      cnt_ff <= 6'h00;
      neg_q_ff <= 1'b0;
      neg_r_ff <= 1'b0;
    end else if (ce_i) begin
      if (start_i) begin
        state_ff <= ST_RUN;
        rem_ff <= first[63:32];
        quo_ff <= first[31:0];
        dvs_ff <= rt_mag;
        iter_ff <= `MDU_DIV_BITS - skip - 6'h01;
        cnt_ff <= lat - 6'h01;
        neg_q_ff <= rs_neg ^ rt_neg;
        neg_r_ff <= rs_neg;
      end else begin
        state_ff <= nxt_state;
        if (state_ff == ST_RUN) begin
          cnt_ff <= cnt_ff - 6'h01;
          if (iter_ff != 6'h00) begin
            rem_ff <= step[63:32];
            quo_ff <= step[31:0];
            iter_ff <= iter_ff - 6'h01;
          end
        end
      end
    end
  end

  assign busy_o = (state_ff == ST_RUN);
  assign last_o = (state_ff == ST_RUN) && (cnt_ff == 6'h01);
  // sign fix-up; divide by zero returns ones in the low 32-skip magnitude bits, left undefined
  assign quo_o = neg_q_ff ? (32'h0000_0000 - quo_ff) : quo_ff;
  assign rem_o = neg_r_ff ? (32'h0000_0000 - rem_ff) : rem_ff;
endmodule
`default_nettype wire

// ===== verilog/mdu_top.v
// multiply/divide unit: booth multiplier, hi/lo pair, divider and issue interlocks
`default_nettype none
`include "mdu_map.vh"

module mdu_top (
  input wire REF_CLK_I,
  input wire RST_N_I,
  input wire CE_I,
  input wire OP_VALID_I,
  input wire [3:0] OP_CODE_I,
  input wire [31:0] RS_I,
  input wire [31:0] RT_I,
  output wire OP_READY_O,
  output wire HILO_BUSY_O,
  output wire GPR_BUSY_O,
  output wire DIV_BUSY_O,
  output wire [31:0] HI_O,
  output wire [31:0] LO_O,
  output wire GPR_VALID_O,
  output wire [31:0] GPR_DATA_O
);
  reg [31:0] hi_ff;
  reg [31:0] lo_ff;
  reg pass2_ff;
  reg [3:0] op_ff;
  reg sgn_ff;
  reg [32:0] a_ff;
  reg [15:0] rth_ff;
  reg [49:0] part_ff;
  reg gstage_ff;
  reg [31:0] gres_ff;
  reg gvalid_ff;
  reg [31:0] gdata_ff;
  wire div_busy;
  wire div_last;
  wire [31:0] div_quo;
  wire [31:0] div_rem;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // radix-4 booth product of a 33-bit and a 17-bit signed operand
  function [49:0] booth;
    input [32:0] a;
    input [16:0] b;
    reg [18:0] bx;
    reg [49:0] ae;
    reg [49:0] acc;
    reg [2:0] d;
    integer k;
    begin
      bx = {b[16], b, 1'b0}; // ninth digit reads one sign copy above b
      ae = {{17{a[32]}}, a};
      acc = 50'h0;
      for (k = 0; k < 9; k = k + 1) begin
        d = bx[2*k +: 3];
        case (d)
          3'b001, 3'b010: acc = acc + (ae << (2*k));
          3'b011: acc = acc + (ae << (2*k + 1));
          3'b100: acc = acc - (ae << (2*k + 1));
          3'b101, 3'b110: acc = acc - (ae << (2*k));
          default: acc = acc;
        endcase
      end
      booth = acc;
    end
  endfunction

  // signed flavour of an opcode
  function op_signed;
    input [3:0] op;
    begin
      op_signed = (op == `MDU_OP_MULT) || (op == `MDU_OP_MADD) ||
        (op == `MDU_OP_MSUB) || (op == `MDU_OP_MUL) || (op == `MDU_OP_DIV);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode and issue interlock

  wire is_mul = (OP_CODE_I <= `MDU_OP_MUL);
  wire is_div = (OP_CODE_I == `MDU_OP_DIV) || (OP_CODE_I == `MDU_OP_DIVU);
  wire sgn = op_signed(OP_CODE_I);
  // size from rt alone: does rt fit a 16-bit slice
  wire rt_wide = sgn ? ~((&RT_I[31:15]) | ~(|RT_I[31:15])) : (|RT_I[31:16]);

  // a second pass owns the array and the accumulator for one more cycle,
  // so nothing issues then; a divide may follow a divide on its last cycle
  wire div_block = div_busy & ~(div_last & is_div);
  assign OP_READY_O = ~pass2_ff & ~div_block;
  wire accept = OP_VALID_I & OP_READY_O & (is_mul | is_div);

  ////////////////////////////////////////////////////////////////////////
  // multiplier passes

  // first pass: whole rs by low slice of rt (sign-extended only if it is all of rt)
  wire [32:0] a_in = {sgn & RS_I[31], RS_I};
  wire [16:0] b_lo = {~rt_wide & sgn & RT_I[15], RT_I[15:0]};
  wire [49:0] p1 = booth(a_in, b_lo);
  // second pass: same rs by high slice, weighted by 2^16
  wire [49:0] p2 = booth(a_ff, {sgn_ff & rth_ff[15], rth_ff});
  wire [63:0] prod1 = {{14{p1[49]}}, p1};
  // bits of p2 above 47 land beyond the 64-bit product once weighted by 2^16
  wire [63:0] prod2 = {{14{part_ff[49]}}, part_ff} + {p2[47:0], 16'h0000};

  // the finishing pass of either length
  wire fin_go = pass2_ff | (accept & is_mul & ~rt_wide);
  wire [3:0] fin_op = pass2_ff ? op_ff : OP_CODE_I;
  wire [63:0] fin_prod = pass2_ff ? prod2 : prod1;
  reg [63:0] acc_val;

  // accumulate into or overwrite the hi/lo pair
  always @* begin
    case (fin_op)
      `MDU_OP_MADD, `MDU_OP_MADDU: acc_val = {hi_ff, lo_ff} + fin_prod;
      `MDU_OP_MSUB, `MDU_OP_MSUBU: acc_val = {hi_ff, lo_ff} - fin_prod;
      default: acc_val = fin_prod;
    endcase
  end

  // multiply pipeline state; advances on every enabled clock regardless of
  // what the integer pipeline is doing
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pass2_ff <= 1'b0;
      op_ff <= `MDU_OP_MULT;
      sgn_ff <= 1'b0;
      a_ff <= 33'h0;
      rth_ff <= 16'h0000;
      part_ff <= 50'h0;
    end else if (CE_I) begin
      pass2_ff <= accept & is_mul & rt_wide;
      if (accept & is_mul & rt_wide) begin
        op_ff <= OP_CODE_I;
        sgn_ff <= sgn;
        a_ff <= a_in;
        rth_ff <= RT_I[31:16];
        part_ff <= p1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result registers

  // hi/lo: a multiply finishing or the divider's last cycle, never both
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hi_ff <= 32'h0000_0000;
      lo_ff <= 32'h0000_0000;
    end else if (CE_I) begin
      if (div_last) begin
        hi_ff <= div_rem;
        lo_ff <= div_quo;
      end else if (fin_go && (fin_op != `MDU_OP_MUL)) begin
        hi_ff <= acc_val[63:32];
        lo_ff <= acc_val[31:0];
      end
    end
  end

  // gpr product: one extra stage after the multiplier, hi/lo untouched
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      gstage_ff <= 1'b0;
      gres_ff <= 32'h0000_0000;
      gvalid_ff <= 1'b0;
      gdata_ff <= 32'h0000_0000;
    end else if (CE_I) begin
      gstage_ff <= fin_go && (fin_op == `MDU_OP_MUL);
      if (fin_go && (fin_op == `MDU_OP_MUL)) begin
        gres_ff <= fin_prod[31:0];
      end
      gvalid_ff <= gstage_ff;
      if (gstage_ff) begin
        gdata_ff <= gres_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // divider

  mdu_div u_div (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .start_i(accept & is_div),
    .sign_i(sgn),
    .rs_i(RS_I),
    .rt_i(RT_I),
    .busy_o(div_busy),
    .last_o(div_last),
    .quo_o(div_quo),
    .rem_o(div_rem)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs and reader interlocks

  // pending writes hold back readers until the value lands
  assign HILO_BUSY_O = div_busy | (pass2_ff & (op_ff != `MDU_OP_MUL));
  assign GPR_BUSY_O = gstage_ff | (pass2_ff & (op_ff == `MDU_OP_MUL));
  assign DIV_BUSY_O = div_busy;
  assign HI_O = hi_ff;
  assign LO_O = lo_ff;
  assign GPR_VALID_O = gvalid_ff;
  assign GPR_DATA_O = gdata_ff;
endmodule
`default_nettype wire

// ===== verif/mdu_chk_sva.sv
// checker: issue and result timing at the ports of the multiply/divide unit
`default_nettype none
`include "mdu_map.vh"

module mdu_chk (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic OP_VALID_I,
  input wire logic [3:0] OP_CODE_I,
  input wire logic [31:0] RS_I,
  input wire logic [31:0] RT_I,
  input wire logic OP_READY_O,
  input wire logic HILO_BUSY_O,
  input wire logic GPR_BUSY_O,
  input wire logic DIV_BUSY_O,
  input wire logic [31:0] HI_O,
  input wire logic [31:0] LO_O,
  input wire logic GPR_VALID_O,
  input wire logic [31:0] GPR_DATA_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take, is_u, sht, is_div;
  logic [63:0] prod_u;
  logic [5:0] busy_cnt_ff, nxt_busy_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // issue decode, operand size taken from rt alone
  assign take = CE_I & OP_VALID_I & OP_READY_O & (OP_CODE_I <= `MDU_OP_DIVU);
  assign is_u = (OP_CODE_I == `MDU_OP_MULTU) | (OP_CODE_I == `MDU_OP_MADDU) |
    (OP_CODE_I == `MDU_OP_MSUBU);
  assign sht = is_u ? (RT_I[31:16] == 16'h0000) : (&RT_I[31:15] | ~|RT_I[31:15]);
  assign is_div = (OP_CODE_I == `MDU_OP_DIV) | (OP_CODE_I == `MDU_OP_DIVU);
  assign prod_u = {32'h0000_0000, RS_I} * {32'h0000_0000, RT_I};

  // busy run length in enabled cycles; restarts at zero on a divide take so a divide
  // chained onto the last cycle of another counts alike, and frozen cycles do not count
  assign nxt_busy_cnt = (take & is_div) ? 6'h00 :
    (DIV_BUSY_O ? busy_cnt_ff + {5'h00, CE_I} : 6'h00);
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      busy_cnt_ff <= 6'h00;
    end else begin
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  ////////////////////////////////////////////////////////////////////////////
  property p_long_stall;
    take & (OP_CODE_I <= `MDU_OP_MUL) & ~sht |=> !OP_READY_O;
  endproperty
  a_long_stall: assert property (p_long_stall) else $error("second pass not stalled");
  property p_short_rate;
    take & (OP_CODE_I <= `MDU_OP_MUL) & sht |=> OP_READY_O;
  endproperty
  a_short_rate: assert property (p_short_rate) else $error("short multiply stalled");
  property p_short_val;
    take & (OP_CODE_I == `MDU_OP_MULTU) & sht |=> !HILO_BUSY_O && {HI_O, LO_O} == $past(prod_u);
  endproperty
  a_short_val: assert property (p_short_val) else $error("short product late");
  property p_long_val;
    take & (OP_CODE_I == `MDU_OP_MULTU) & ~sht |=> HILO_BUSY_O ##1
      (!HILO_BUSY_O && {HI_O, LO_O} == $past(prod_u, 2));
  endproperty
  a_long_val: assert property (p_long_val) else $error("long product late");
  property p_gpr_short;
    take & (OP_CODE_I == `MDU_OP_MUL) & sht |=> GPR_BUSY_O ##1 GPR_VALID_O;
  endproperty
  a_gpr_short: assert property (p_gpr_short) else $error("short gpr result late");
  property p_gpr_long;
    take & (OP_CODE_I == `MDU_OP_MUL) & ~sht |=> GPR_BUSY_O [*2] ##1 GPR_VALID_O;
  endproperty
  a_gpr_long: assert property (p_gpr_long) else $error("long gpr result late");
  property p_div_len;
    $fell(DIV_BUSY_O) |-> busy_cnt_ff inside {6'h0b, 6'h12, 6'h19, 6'h20};
  endproperty
  a_div_len: assert property (p_div_len) else $error("divide length wrong");
  property p_div_block;
    DIV_BUSY_O && OP_VALID_I && !is_div |-> !OP_READY_O && HILO_BUSY_O;
  endproperty
  a_div_block: assert property (p_div_block) else $error("issue during divide");
endmodule

bind mdu_top mdu_chk chk_u (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
  .OP_VALID_I(OP_VALID_I), .OP_CODE_I(OP_CODE_I), .RS_I(RS_I), .RT_I(RT_I),
  .OP_READY_O(OP_READY_O), .HILO_BUSY_O(HILO_BUSY_O), .GPR_BUSY_O(GPR_BUSY_O),
  .DIV_BUSY_O(DIV_BUSY_O), .HI_O(HI_O), .LO_O(LO_O), .GPR_VALID_O(GPR_VALID_O),
  .GPR_DATA_O(GPR_DATA_O));
`default_nettype wire

// ===== verif/mdu_iu_model.sv
// integer pipeline model: offers instructions and holds them while stalled
`default_nettype none

module mdu_iu_model (
  input wire logic clk_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic [3:0] code_o,
  output logic [31:0] rs_o,
  output logic [31:0] rt_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // defined lines from time zero
  initial begin
    valid_o = 1'b0;
    code_o = 4'hf;
    rs_o = 32'h0000_0000;
    rt_o = 32'h0000_0000;
  end

  // called at a rising edge; the offer stays put until the edge that takes it
  task automatic issue(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
    int n;
    n = 0;
    valid_o <= 1'b1;
    code_o <= op;
    rs_o <= a;
    rt_o <= b;
    do begin
      @(posedge clk_i);
      n++;
    end while (!ready_i && n < 200);
  endtask

  // released lines turn inverted so stale operands cannot pass for fresh ones
  task automatic idle;
    valid_o <= 1'b0;
    code_o <= ~code_o;
    rs_o <= ~rs_o;
    rt_o <= ~rt_o;
  endtask
endmodule
`default_nettype wire

// ===== verif/multiply_divide_unit_tb.sv
// self-checking bench for the multiply/divide unit
`default_nettype none
`include "mdu_map.vh"

module multiply_divide_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic valid, ready, hilo_busy, gpr_busy, div_busy, gpr_valid;
  logic [3:0] code, op;
  logic [31:0] rs, rt, hi, lo, gpr_data, a, b, gexp;
  logic [63:0] acc = 64'h0000_0000_0000_0000;
  int cyc = 0;
  int n_fail = 0;
  int total_checks = 0;
  int t1, k;

  ////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  // cycle count doubles as hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  mdu_top dut_u (.REF_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .OP_VALID_I(valid),
    .OP_CODE_I(code), .RS_I(rs), .RT_I(rt), .OP_READY_O(ready), .HILO_BUSY_O(hilo_busy),
    .GPR_BUSY_O(gpr_busy), .DIV_BUSY_O(div_busy), .HI_O(hi), .LO_O(lo),
    .GPR_VALID_O(gpr_valid), .GPR_DATA_O(gpr_data));
  mdu_iu_model iu_u (.clk_i(clk), .ready_i(ready), .valid_o(valid), .code_o(code),
    .rs_o(rs), .rt_o(rt));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk1(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk64(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkint(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      n_fail++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // reference arithmetic; signed divide truncates, remainder keeps dividend sign
  function automatic logic [63:0] mref(input logic [3:0] o, input logic [31:0] x,
                                       input logic [31:0] y, input logic [63:0] c);
    logic [63:0] sp, up;
    sp = longint'($signed(x)) * longint'($signed(y));
    up = {32'h0000_0000, x} * {32'h0000_0000, y};
    case (o)
      `MDU_OP_MULT: return sp;
      `MDU_OP_MULTU: return up;
      `MDU_OP_MADD: return c + sp;
      `MDU_OP_MADDU: return c + up;
      `MDU_OP_MSUB: return c - sp;
      `MDU_OP_MSUBU: return c - up;
      `MDU_OP_DIV: return {32'($signed(x) % $signed(y)), 32'($signed(x) / $signed(y))};
      default: return {x % y, x / y};
    endcase
  endfunction
  // short means one pass through the 32x16 array
  function automatic bit shrt(input logic [3:0] o, input logic [31:0] y);
    if (o == `MDU_OP_MULTU || o == `MDU_OP_MADDU || o == `MDU_OP_MSUBU) return y[31:16] == 0;
    return &y[31:15] || ~|y[31:15];
  endfunction

  // offer one op at the current edge and update the model when it is taken
  task automatic send(input logic [3:0] o, input logic [31:0] x, input logic [31:0] y);
    logic [63:0] e;
    iu_u.issue(o, x, y);
    t1 = cyc;
    e = mref(o == `MDU_OP_MUL ? `MDU_OP_MULT : o, x, y, acc);
    if (o == `MDU_OP_MUL) gexp = e[31:0];
    else acc = e;
  endtask

  // lone op: busy in the cycle before the result, result exactly at lat
  task automatic run_op(input logic [3:0] o, input logic [31:0] x, input logic [31:0] y,
                        input int lat);
    @(posedge clk);
    send(o, x, y);
    iu_u.idle();
    if (lat > 1) begin
      repeat (lat - 2) @(posedge clk);
      #1;
      chk1("busy", 1'b1, o == `MDU_OP_MUL ? gpr_busy : hilo_busy);
      @(posedge clk);
    end
    #1;
    if (o == `MDU_OP_MUL) begin
      chk1("gpr valid", 1'b1, gpr_valid);
      chk64("gpr data", {32'h0000_0000, gexp}, {32'h0000_0000, gpr_data});
    end else begin
      chk1("hilo busy", 1'b0, hilo_busy);
      chk64("hi lo", acc, {hi, lo});
    end
  endtask

  // six ops offered back to back; spacing shows the repeat rate
  task automatic burst(input logic [3:0] o, input bit lng, input int rate);
    int ts;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      send(o, $urandom,
           lng ? ($urandom | 32'h4000_0000) & 32'h7fff_ffff : $urandom_range(0, 32'h7fff));
      if (i == 0) ts = t1;
    end
    iu_u.idle();
    chkint("spacing", 5 * rate, t1 - ts);
    repeat (4) @(posedge clk);
    #1;
    chk64("burst", o == `MDU_OP_MUL ? {32'h0000_0000, gexp} : acc,
      o == `MDU_OP_MUL ? {32'h0000_0000, gpr_data} : {hi, lo});
  endtask

  // second op right behind a 16-bit divide (latency 19)
  task automatic after_div(input logic [3:0] o, input int gap, input int lat);
    int ts;
    @(posedge clk);
    send(`MDU_OP_DIVU, 32'h0000_1234, 32'h0000_0007);
    ts = t1;
    send(o, 32'h0000_0055, 32'h0000_0003);
    iu_u.idle();
    chkint("take after divide", gap, t1 - ts);
    repeat (lat) @(posedge clk);
    #1;
    chk64("after divide", acc, {hi, lo});
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    a = $urandom(32'h1637_a37a);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 42; i++) begin
      op = 4'(i % 7);
      b = $urandom >> $urandom_range(0, 31);
      if ($urandom_range(0, 1) == 1) b = ~b;
      run_op(op, $urandom, b, (op == `MDU_OP_MUL ? 2 : 1) + (shrt(op, b) ? 0 : 1));
    end
    $display("test multiply done");
    for (int i = 0; i < 16; i++) begin
      k = i % 4;
      op = i[2] ? `MDU_OP_DIV : `MDU_OP_DIVU;
      a = (32'h0000_0040 << (8 * k)) | ($urandom & ((32'h0000_0040 << (8 * k)) - 1));
      b = $urandom_range(1, 32'hffff);
      if (op == `MDU_OP_DIV && i[3]) a = -a;
      if (op == `MDU_OP_DIV && $urandom_range(0, 1) == 1) b = -b;
      run_op(op, a, b, 12 + 7 * k);
    end
    $display("test divide done");
    burst(`MDU_OP_MADD, 1'b0, 1);
    burst(`MDU_OP_MSUBU, 1'b1, 2);
    burst(`MDU_OP_MUL, 1'b0, 1);
    burst(`MDU_OP_MUL, 1'b1, 2);
    $display("test burst done");
    after_div(`MDU_OP_MULT, 19, 1);
    after_div(`MDU_OP_DIVU, 18, 12);
    $display("test chain done");
    // a low clock enable must stretch an 8-bit divide by exactly the frozen cycles
    @(posedge clk);
    send(`MDU_OP_DIVU, 32'h0000_00c8, 32'h0000_0009);
    iu_u.idle();
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk1("frozen busy", 1'b1, div_busy);
    @(posedge clk);
    #1;
    chk1("frozen done", 1'b0, div_busy);
    chk64("frozen divide", acc, {hi, lo});
    $display("test freeze done");
    give_verdict();
  end
endmodule
`default_nettype wire
